// [design/cqs_queue.sv]
// package of shared constants and the shadow instruction queue module
package cqs_pkg;
  localparam int          QDEPTH       = 6;
  localparam int          QIDX_W       = 3;
  localparam int          BYTE_W       = 8;
  localparam logic [1:0]  QS_NOP       = 2'h0;
  localparam logic [1:0]  QS_FIRST     = 2'h1;
  localparam logic [1:0]  QS_FLUSH     = 2'h2;
  localparam logic [1:0]  QS_NEXT      = 2'h3;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [2:0]  CNT_RST      = 3'h0;
  localparam int          RST_SYNC_LEN = 2;
  typedef enum logic [1:0] {
    CQS_BUS_IDLE = 2'b00,
    CQS_BUS_WAIT = 2'b01,
    CQS_BUS_DONE = 2'b10
  } cqs_bus_t;
endpackage

`timescale 1ns/1ps
module cqs_queue (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       push,
  input  wire logic [7:0] push_byte,
  input  wire logic       pop,
  input  wire logic       flush,
  output logic      [7:0] head_byte,
  output logic      [2:0] count
);
  logic [7:0] mem_q [cqs_pkg::QDEPTH];
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       do_pop;
  logic       do_push;
  logic [2:0] base;

  ////////////////////////////////////////////////////////////////////////
  // flush drops everything, a byte fetched in the same cycle still enters
  assign do_pop  = pop && !flush && (cnt_q != cqs_pkg::CNT_RST);
  assign base    = flush ? cqs_pkg::CNT_RST : (do_pop ? cnt_q - 3'h1 : cnt_q);
  // a full queue takes a byte only when popped or flushed in the same cycle; a fetch past its depth is dropped
  assign do_push = push && (base != 3'(cqs_pkg::QDEPTH));
  assign cnt_d   = do_push ? base + 3'h1 : base;
  assign head_byte = mem_q[0];
  assign count     = cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= cqs_pkg::CNT_RST;
    end else if (clr) begin
      cnt_q <= cqs_pkg::CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // shift toward the head on pop, write the new byte at the tail
  for (genvar i = 0; i < cqs_pkg::QDEPTH; i++) begin : g_slot
    logic [7:0] nxt;
    if (i == cqs_pkg::QDEPTH - 1) begin : g_last
      assign nxt = mem_q[i];
    end else begin : g_mid
      assign nxt = do_pop ? mem_q[i+1] : mem_q[i];
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[i] <= cqs_pkg::BYTE_RST;
      end else if (do_push && (base == 3'(i))) begin
        mem_q[i] <= push_byte;
      end else begin
        mem_q[i] <= nxt;
      end
    end
  end
endmodule

// [design/cqs_port.sv]
// top of the coprocessor host status port
`timescale 1ns/1ps
module cqs_port (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       host_reset,
  input  wire logic       queue_status_hi,
  input  wire logic       queue_status_lo,
  input  wire logic       host_fetch,
  input  wire logic [7:0] host_data,
  input  wire logic       ready,
  input  wire logic       exec_start,
  input  wire logic       exec_done,
  input  wire logic       exc_raise,
  input  wire logic       exc_clear,
  input  wire logic       int_enable,
  input  wire logic       bus_req,
  output logic            busy,
  output logic            intr,
  output logic            bus_waiting,
  output logic            bus_done,
  output logic            opcode_valid,
  output logic            opcode_first,
  output logic      [7:0] opcode_byte,
  output logic      [2:0] queue_count
);
  logic [1:0]        rst_sync_q;
  logic              rst_n;
  logic [1:0]        hrst_q;
  logic [1:0]        qs_hi_q;
  logic [1:0]        qs_lo_q;
  logic [1:0]        fetch_q;
  logic [7:0]        data_m_q;
  logic [7:0]        data_s_q;
  logic [1:0]        rdy_q;
  logic              clr;
  logic [1:0]        qs;
  logic              qs_pop;
  logic              qs_flush;
  logic              qs_first;
  logic              pop_ok;
  logic [7:0]        head;
  logic              exec_q;
  logic              exec_d;
  logic              exc_q;
  logic              exc_d;
  logic              busy_q;
  logic              intr_q;
  logic              opv_q;
  logic              opf_q;
  logic [7:0]        opb_q;
  cqs_pkg::cqs_bus_t bus_q;
  cqs_pkg::cqs_bus_t bus_d;
  logic [1:0]        fresh_q;
  logic              rdy_ok;

  ////////////////////////////////////////////////////////////////////////
  // local reset release and pin synchronizers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // host and ready pins pass two flops; data bits are sampled alongside the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrst_q   <= 2'h0;
      qs_hi_q  <= 2'h0;
      qs_lo_q  <= 2'h0;
      fetch_q  <= 2'h0;
      rdy_q    <= 2'h0;
      data_m_q <= cqs_pkg::BYTE_RST;
      data_s_q <= cqs_pkg::BYTE_RST;
    end else begin
      hrst_q   <= {hrst_q[0], host_reset};
      qs_hi_q  <= {qs_hi_q[0], queue_status_hi};
      qs_lo_q  <= {qs_lo_q[0], queue_status_lo};
      fetch_q  <= {fetch_q[0], host_fetch};
      rdy_q    <= {rdy_q[0], ready};
      data_m_q <= host_data;
      data_s_q <= data_m_q;
    end
  end

  // synced host reset clears count, opcode, busy, interrupt and bus state at once (queue bytes kept), no matter how long held
  assign clr = hrst_q[1];

  ////////////////////////////////////////////////////////////////////////
  // queue status decode
  // every status code is compared the same way, so the decode lives in one place
  function automatic logic qs_code_is(input logic [1:0] code, input logic [1:0] want);
    qs_code_is = (code == want);
  endfunction

  assign qs       = {qs_hi_q[1], qs_lo_q[1]};
  assign qs_first = qs_code_is(qs, cqs_pkg::QS_FIRST);
  assign qs_pop   = qs_first || qs_code_is(qs, cqs_pkg::QS_NEXT);
  assign qs_flush = qs_code_is(qs, cqs_pkg::QS_FLUSH);
  // a pop on an empty queue is refused: no strobe, and the last byte stays shown
  assign pop_ok   = qs_pop && (queue_count != cqs_pkg::CNT_RST);

  cqs_queue u_queue (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .clr       (clr),
    .push      (fetch_q[1]),
    .push_byte (data_s_q),
    .pop       (qs_pop),
    .flush     (qs_flush),
    .head_byte (head),
    .count     (queue_count)
  );

  // removed byte is presented for one cycle, tagged first or subsequent
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opv_q <= 1'b0;
      opf_q <= 1'b0;
      opb_q <= cqs_pkg::BYTE_RST;
    end else if (clr) begin
      opv_q <= 1'b0;
      opf_q <= 1'b0;
      opb_q <= cqs_pkg::BYTE_RST;
    end else begin
      opv_q <= pop_ok;
      opf_q <= qs_first;
      opb_q <= pop_ok ? head : opb_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // busy and exception tracking; a set wins over a clear in the same cycle
  assign exec_d = exec_start || (exec_q && !exec_done);
  assign exc_d  = (exc_raise && (exec_q || exec_start)) || (exc_q && !exc_clear);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exec_q <= 1'b0;
      exc_q  <= 1'b0;
      busy_q <= 1'b0;
      intr_q <= 1'b0;
    end else if (clr) begin
      exec_q <= 1'b0;
      exc_q  <= 1'b0;
      busy_q <= 1'b0;
      intr_q <= 1'b0;
    end else begin
      exec_q <= exec_d;
      exc_q  <= exc_d;
      busy_q <= exec_d || exc_d;
      intr_q <= exc_d && int_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // own bus cycle: wait states until synced ready is seen high
  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      cqs_pkg::CQS_BUS_IDLE: begin
        if (bus_req) begin
          bus_d = cqs_pkg::CQS_BUS_WAIT;
        end
      end
      cqs_pkg::CQS_BUS_WAIT: begin
        if (rdy_ok) begin
          bus_d = cqs_pkg::CQS_BUS_DONE;
        end
      end
      cqs_pkg::CQS_BUS_DONE: begin
        bus_d = cqs_pkg::CQS_BUS_IDLE;
      end
      default: begin
        bus_d = cqs_pkg::CQS_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= cqs_pkg::CQS_BUS_IDLE;
    end else if (clr) begin
      bus_q <= cqs_pkg::CQS_BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  // a synced ready sample taken before this wait state began is ignored; a memory
  // still holding ready from the last transfer would otherwise end the next one early
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fresh_q <= 2'h0;
    end else if (clr || (bus_q != cqs_pkg::CQS_BUS_WAIT)) begin
      fresh_q <= 2'h0;
    end else begin
      fresh_q <= {fresh_q[0], 1'b1};
    end
  end
  assign rdy_ok = rdy_q[1] && fresh_q[1];

  assign bus_waiting  = (bus_q == cqs_pkg::CQS_BUS_WAIT);
  assign bus_done     = (bus_q == cqs_pkg::CQS_BUS_DONE);
  assign busy         = busy_q;
  assign intr         = intr_q;
  assign opcode_valid = opv_q;
  assign opcode_first = opf_q;
  assign opcode_byte  = opb_q;
endmodule

// [tb/cqs_host_model.sv]
// host side model: memory ready answer and busy wait test
`timescale 1ns/1ps
module cqs_host_model (
  input  wire logic       clk_sys,
  input  wire logic       bus_waiting,
  input  wire logic       busy,
  input  wire logic [3:0] dly,
  output logic            ready,
  output logic            may_go
);
  logic [3:0] wait_q = 4'h0;
  // the host must not pass a wait while busy is high
  assign may_go = !busy;
  // ready stays low outside a transfer; an unknown wait flag counts as no transfer
  always @(posedge clk_sys) begin
    wait_q <= (bus_waiting === 1'b1) ? wait_q + 4'h1 : 4'h0;
    ready  <= (bus_waiting === 1'b1) && (wait_q >= dly);
  end
endmodule

// [tb/cqs_port_assertions.sv]
// checker for the coprocessor host status port
`timescale 1ns/1ps
module cqs_port_chk (
  input logic       clk_sys,
  input logic       rst_b,
  input logic       host_reset,
  input logic       queue_status_hi,
  input logic       queue_status_lo,
  input logic       ready,
  input logic       exec_start,
  input logic       exc_raise,
  input logic       exc_clear,
  input logic       int_enable,
  input logic       bus_req,
  input logic       busy,
  input logic       intr,
  input logic       bus_waiting,
  input logic       bus_done,
  input logic       opcode_valid,
  input logic       opcode_first,
  input logic [2:0] queue_count
);
  logic [3:0] live_q;
  wire  [1:0] qs = {queue_status_hi, queue_status_lo};
  // quiet until both resets have passed the synchronizers, which lag by up to four edges
  wire        quiet = !(&live_q) || host_reset;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) live_q <= 4'h0;
    else live_q <= {live_q[2:0], !host_reset};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (quiet);
  sequence s_exc_seen;
    busy && exc_raise && !exc_clear ##1 !exc_clear;
  endsequence
  a_busy_on: assert property (exec_start |=> busy)
    else $error("busy not raised after start");
  a_exc_hold: assert property (s_exc_seen |=> busy)
    else $error("busy dropped with exception pending");
  a_intr_set: assert property (s_exc_seen ##0 int_enable |=> intr)
    else $error("interrupt missing");
  a_intr_mask: assert property (!int_enable |=> !intr)
    else $error("interrupt while disabled");
  a_bus_wait: assert property (bus_req && !bus_waiting && !bus_done |=> bus_waiting)
    else $error("bus cycle not started");
  a_bus_early: assert property (!ready [*3] |=> !bus_done)
    else $error("transfer done without ready");
  a_opcode_pop: assert property (qs == cqs_pkg::QS_FIRST && queue_count >= 3'h3
    && $past(qs) != cqs_pkg::QS_FLUSH && $past(qs, 2) != cqs_pkg::QS_FLUSH
    |-> ##3 opcode_valid && opcode_first) else $error("first byte not delivered");
  a_reset_clear: assert property (disable iff (!rst_b) host_reset [*5]
    |-> !busy && !intr && !bus_waiting && queue_count == 3'h0) else $error("reset left state");
endmodule
bind cqs_port cqs_port_chk u_cqs_port_chk (
  .clk_sys         (clk_sys),
  .rst_b           (rst_b),
  .host_reset      (host_reset),
  .queue_status_hi (queue_status_hi),
  .queue_status_lo (queue_status_lo),
  .ready           (ready),
  .exec_start      (exec_start),
  .exc_raise       (exc_raise),
  .exc_clear       (exc_clear),
  .int_enable      (int_enable),
  .bus_req         (bus_req),
  .busy            (busy),
  .intr            (intr),
  .bus_waiting     (bus_waiting),
  .bus_done        (bus_done),
  .opcode_valid    (opcode_valid),
  .opcode_first    (opcode_first),
  .queue_count     (queue_count)
);

// [tb/tb_top.sv]
// self-checking testbench for the coprocessor host status port
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [1:0] qs; logic v; logic f; logic [7:0] b; logic [2:0] n;} cqs_row_t;
  logic clk_sys = 1'b0, rst_b = 1'b0, host_reset = 1'b0, host_fetch = 1'b0, ready, may_go;
  logic exec_start = 1'b0, exec_done = 1'b0, exc_raise = 1'b0, exc_clear = 1'b0, v, f;
  logic int_enable = 1'b0, bus_req = 1'b0, busy, intr, bus_waiting, bus_done, opcode_valid;
  logic opcode_first;
  logic [1:0] qs = 2'h0;
  logic [7:0] host_data = 8'h00, opcode_byte;
  logic [2:0] queue_count;
  logic [3:0] dly = 4'h0;
  int mismatches = 0, n_compared = 0, i, k;
  cqs_row_t rows [5] = '{'{2'h1, 1'b1, 1'b1, 8'ha1, 3'h5}, '{2'h3, 1'b1, 1'b0, 8'ha2, 3'h4},
    '{2'h0, 1'b0, 1'b0, 8'ha2, 3'h4}, '{2'h2, 1'b0, 1'b0, 8'ha2, 3'h0},
    '{2'h3, 1'b0, 1'b0, 8'ha2, 3'h0}};
  always #4 clk_sys = ~clk_sys;
  cqs_port u_cqs_port (.*, .queue_status_hi(qs[1]), .queue_status_lo(qs[0]));
  cqs_host_model u_cqs_host_model (.*);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen_v, input logic [7:0] exp_v);
    n_compared++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic close_out();
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    rst_b = 1'b1;
    cyc(4);
    chk(busy, 8'h00);
    host_fetch = 1'b1;
    // seven pushes into six places: the last must be dropped
    for (i = 1; i < 8; i++) begin
      host_data = 8'ha0 + 8'(i);
      cyc(1);
    end
    host_fetch = 1'b0;
    cyc(4);
    chk(queue_count, 8'h06);
    for (i = 0; i < 5; i++) begin
      qs = rows[i].qs;
      cyc(1);
      qs = 2'h0;
      {v, f} = 2'b00;
      for (k = 0; k < 6; k++) begin
        if (opcode_valid === 1'b1) {v, f} = {1'b1, opcode_first};
        cyc(1);
      end
      chk({v, f}, {rows[i].v, rows[i].f});
      chk(opcode_byte, rows[i].b);
      chk(queue_count, rows[i].n);
    end
    for (i = 0; i < 2; i++) begin
      int_enable = i[0];
      pulse(exec_start);
      chk(busy, 8'h01);
      {exc_raise, exec_done} = 2'b11;
      cyc(1);
      {exc_raise, exec_done} = 2'b00;
      cyc(2);
      chk(busy, 8'h01);
      chk(intr, 8'(i));
      chk(may_go, 8'h00);
      pulse(exc_clear);
      cyc(1);
      chk({busy, intr}, 8'h00);
    end
    pulse(exec_start);
    pulse(exec_done);
    chk(busy, 8'h00);
    // an exception outside any instruction is not latched
    pulse(exc_raise);
    cyc(1);
    chk({busy, intr}, 8'h00);
    // a prompt and a slow memory: done follows two edges after ready is first sampled
    for (i = 0; i < 2; i++) begin
      dly = 4'(i * 5);
      pulse(bus_req);
      k = 0;
      while (bus_done !== 1'b1 && k < 40) begin
        k++;
        cyc(1);
      end
      chk(bus_done, 8'h01);
      chk(8'(k), 8'(4 + i * 5));
      // the done state refuses requests, and the old ready sample must drain first
      cyc(4);
    end
    dly = 4'hf;
    pulse(host_fetch);
    pulse(bus_req);
    cyc(3);
    chk(bus_waiting, 8'h01);
    host_reset = 1'b1;
    cyc(5);
    chk({bus_waiting, queue_count}, 8'h00);
    host_reset = 1'b0;
    cyc(6);
    close_out();
  end
  initial begin
    #20000;
    mismatches++;
    close_out();
  end
endmodule
